//--- src/tap_pkg.sv
// constants and types shared by the test access port modules
package tap_pkg;
	typedef enum logic [3:0] {
		ST_TEST_RESET = 4'h0,
		ST_RUN_IDLE = 4'h1,
		ST_SELECT_DR = 4'h2,
		ST_CAPTURE_DR = 4'h3,
		ST_SHIFT_DR = 4'h4,
		ST_EXIT1_DR = 4'h5,
		ST_PAUSE_DR = 4'h6,
		ST_EXIT2_DR = 4'h7,
		ST_UPDATE_DR = 4'h8,
		ST_SELECT_IR = 4'h9,
		ST_CAPTURE_IR = 4'ha,
		ST_SHIFT_IR = 4'hb,
		ST_EXIT1_IR = 4'hc,
		ST_PAUSE_IR = 4'hd,
		ST_EXIT2_IR = 4'he,
		ST_UPDATE_IR = 4'hf
	} tap_state_t;

	localparam int IR_WIDTH = 3;
	localparam int ID_WIDTH = 32;
	localparam int BSR_LEN = 16;
	localparam int OUT_WIDTH = 8;
	localparam int OUT_CTRL_CELL = 15;
	localparam int SYNC_STAGES = 2;

	localparam logic [IR_WIDTH-1:0] INSTR_EXTERNAL_TEST = 3'h0;
	localparam logic [IR_WIDTH-1:0] INSTR_IDENTIFICATION_READ = 3'h1;
	localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE_OUTPUTS_OFF = 3'h2;
	localparam logic [IR_WIDTH-1:0] INSTR_RESERVED_A = 3'h3;
	localparam logic [IR_WIDTH-1:0] INSTR_SAMPLE_PRELOAD = 3'h4;
	localparam logic [IR_WIDTH-1:0] INSTR_RESERVED_B = 3'h5;
	localparam logic [IR_WIDTH-1:0] INSTR_RESERVED_C = 3'h6;
	localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 3'h7;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE_PATTERN = 3'h1;

	// arbitrary neutral identification value, lsb set as the scan convention wants
	localparam logic [ID_WIDTH-1:0] ID_CODE_VALUE = 32'h0a5a_5001;

	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_ID = 4'h8;
	localparam logic [3:0] ADDR_BOUNDARY = 4'hc;
	localparam int CTRL_RESET_BIT = 0;
	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_INSTR_LSB = 4;
	localparam int STATUS_OE_BIT = 7;
	localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : tap_pkg

//--- src/tap_ctrl_if.sv
// link between the port core and its controller state machine
`timescale 1ns/10ps
interface tap_ctrl_if;
	import tap_pkg::*;
	logic tck_rise;
	logic tms;
	logic force_reset;
	tap_state_t state;
	modport fsm (input tck_rise, input tms, input force_reset, output state);
	modport core (output tck_rise, output tms, output force_reset, input state);
endinterface : tap_ctrl_if

//--- src/tap_fsm.sv
// sixteen-state test port controller, stepped on each sampled test clock rise
`timescale 1ns/10ps
module tap_fsm import tap_pkg::*; (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	tap_ctrl_if.fsm ctl // step strobe, mode select, state
);
	tap_state_t state_reg;
	tap_state_t state_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_TEST_RESET: state_next = ctl.tms ? ST_TEST_RESET : ST_RUN_IDLE;
			ST_RUN_IDLE: state_next = ctl.tms ? ST_SELECT_DR : ST_RUN_IDLE;
			ST_SELECT_DR: state_next = ctl.tms ? ST_SELECT_IR : ST_CAPTURE_DR;
			ST_CAPTURE_DR: state_next = ctl.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: state_next = ctl.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: state_next = ctl.tms ? ST_UPDATE_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: state_next = ctl.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: state_next = ctl.tms ? ST_UPDATE_DR : ST_SHIFT_DR;
			ST_UPDATE_DR: state_next = ctl.tms ? ST_SELECT_DR : ST_RUN_IDLE;
			ST_SELECT_IR: state_next = ctl.tms ? ST_TEST_RESET : ST_CAPTURE_IR;
			ST_CAPTURE_IR: state_next = ctl.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: state_next = ctl.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: state_next = ctl.tms ? ST_UPDATE_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: state_next = ctl.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: state_next = ctl.tms ? ST_UPDATE_IR : ST_SHIFT_IR;
			ST_UPDATE_IR: state_next = ctl.tms ? ST_SELECT_DR : ST_RUN_IDLE;
		endcase
	end

	// five rises with mode select high reach reset from any state by the table above
	always_ff @(posedge aclk) begin
		if (!aresetn || ctl.force_reset) begin
			state_reg <= ST_TEST_RESET;
		end else if (ctl.tck_rise) begin
			state_reg <= state_next;
		end
	end

	assign ctl.state = state_reg;
endmodule : tap_fsm

//--- src/memory_boundary_scan_tap.sv
// boundary scan test access port with register access over axi4-lite
//
// Overview of operation
// - inputs sampled on test clock rise
// - outputs updated on test clock fall
// - data out driven only while shifting
// - serial input feeds selected register msb
// - serial output shows selected register lsb
// - five high mode-select rises reset controller
// - port reset leaves memory operation alone
// - power-up reset, serial output starts off
// - exactly one register between serial pins
// - three-bit instruction register shifts in IR
// - identification instruction loaded at reset
// - instruction capture loads binary 01
// - bypass register is one bit
// - bypass capture clears it to zero
// - one boundary cell per input pin
// - data capture loads ring, then shifts
// - three instructions select boundary register
// - identification capture loads 32-bit code
// - all eight instruction codes decoded
// - new instruction applies at instruction update
// - mode select floats high through pull-up; no pull-up here, only the tms and tdi synchronisers reset high
// - outputs-off instruction forces memory outputs off
// - external test drives preloaded pin values
// - control cell gates bus, preset high
// - preload instruction snapshots all pins
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module memory_boundary_scan_tap import tap_pkg::*; (
	input wire logic aclk, // system clock, 250 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [3:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [3:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic tck, // test clock pin
	input wire logic tms, // mode select pin
	input wire logic tdi, // serial data in pin
	output logic tdo, // serial data out
	output logic tdo_oe, // serial data out enable, high drives
	input wire logic [BSR_LEN-2:0] ring_in, // memory pin levels for capture
	output logic mem_out_force_z, // force memory outputs off
	output logic mem_out_test_drive, // drive memory outputs from scan cells
	output logic [OUT_WIDTH-1:0] mem_out_test_data // scan values for memory outputs
);
	tap_ctrl_if ctl ();

	logic [SYNC_STAGES:0] tck_sync_reg;
	logic [SYNC_STAGES-1:0] tms_sync_reg;
	logic [SYNC_STAGES-1:0] tdi_sync_reg;
	logic [BSR_LEN-2:0] ring_meta_reg;
	logic [BSR_LEN-2:0] ring_sync_reg;
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;

	logic [IR_WIDTH-1:0] ir_reg;
	logic [IR_WIDTH-1:0] ir_shift_reg;
	logic bypass_reg;
	logic [ID_WIDTH-1:0] id_shift_reg;
	logic [BSR_LEN-1:0] bsr_shift_reg;
	logic [BSR_LEN-1:0] bsr_update_reg;
	logic sel_boundary;
	logic sel_ident;
	logic serial_lsb;

	logic ctrl_reset_reg;
	logic aw_held_reg;
	logic aw_held_next;
	logic w_held_reg;
	logic w_held_next;
	logic [3:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_next;
	logic do_write;
	logic rvalid_next;
	logic [31:0] read_word;
	logic read_hit;

	// pin synchronisers; only the second stage and later are looked at
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tck_sync_reg <= '0;
			tms_sync_reg <= '1;
			tdi_sync_reg <= '1;
		end else begin
			tck_sync_reg <= {tck_sync_reg[SYNC_STAGES-1:0], tck};
			tms_sync_reg <= {tms_sync_reg[SYNC_STAGES-2:0], tms};
			tdi_sync_reg <= {tdi_sync_reg[SYNC_STAGES-2:0], tdi};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ring_meta_reg <= '0;
			ring_sync_reg <= '0;
		end else begin
			ring_meta_reg <= ring_in;
			ring_sync_reg <= ring_meta_reg;
		end
	end

	// tck held low by an unused board gives no edges, so the port rests in reset
	assign tck_rise = tck_sync_reg[SYNC_STAGES-1] && !tck_sync_reg[SYNC_STAGES];
	assign tck_fall = !tck_sync_reg[SYNC_STAGES-1] && tck_sync_reg[SYNC_STAGES];
	assign tms_s = tms_sync_reg[SYNC_STAGES-1];
	assign tdi_s = tdi_sync_reg[SYNC_STAGES-1];

	assign ctl.tck_rise = tck_rise;
	assign ctl.tms = tms_s;
	assign ctl.force_reset = ctrl_reset_reg;

	tap_fsm u_fsm (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl(ctl)
	);

	// instruction decode; every code lands somewhere, reserved ones on bypass
	always_comb begin
		sel_boundary = 1'b0;
		sel_ident = 1'b0;
		unique case (ir_reg)
			INSTR_EXTERNAL_TEST: sel_boundary = 1'b1;
			INSTR_SAMPLE_OUTPUTS_OFF: sel_boundary = 1'b1;
			INSTR_SAMPLE_PRELOAD: sel_boundary = 1'b1;
			INSTR_IDENTIFICATION_READ: sel_ident = 1'b1;
			INSTR_BYPASS: sel_boundary = 1'b0;
			INSTR_RESERVED_A, INSTR_RESERVED_B, INSTR_RESERVED_C: sel_ident = 1'b0;
		endcase
	end

	always_comb begin
		if (ctl.state == ST_SHIFT_IR) begin
			serial_lsb = ir_shift_reg[0];
		end else if (sel_boundary) begin
			serial_lsb = bsr_shift_reg[0];
		end else if (sel_ident) begin
			serial_lsb = id_shift_reg[0];
		end else begin
			serial_lsb = bypass_reg;
		end
	end

	// instruction path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ir_reg <= INSTR_IDENTIFICATION_READ;
			ir_shift_reg <= IR_CAPTURE_PATTERN;
		end else if (ctl.state == ST_TEST_RESET) begin
			ir_reg <= INSTR_IDENTIFICATION_READ;
		end else if (tck_rise) begin
			unique case (ctl.state)
				ST_CAPTURE_IR: ir_shift_reg <= IR_CAPTURE_PATTERN;
				ST_SHIFT_IR: ir_shift_reg <= {tdi_s, ir_shift_reg[IR_WIDTH-1:1]};
				ST_UPDATE_IR: ir_reg <= ir_shift_reg;
				default: ir_shift_reg <= ir_shift_reg;
			endcase
		end
	end

	// bypass and identification data registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bypass_reg <= 1'b0;
			id_shift_reg <= ID_CODE_VALUE;
		end else if (tck_rise && !sel_boundary) begin
			if (ctl.state == ST_CAPTURE_DR) begin
				bypass_reg <= 1'b0;
				if (sel_ident) begin
					id_shift_reg <= ID_CODE_VALUE;
				end
			end else if (ctl.state == ST_SHIFT_DR) begin
				if (sel_ident) begin
					id_shift_reg <= {tdi_s, id_shift_reg[ID_WIDTH-1:1]};
				end else begin
					bypass_reg <= tdi_s;
				end
			end
		end
	end

	// boundary cells; control cell recaptures its own preload, the rest the pin ring
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bsr_shift_reg <= '0;
		end else if (tck_rise && sel_boundary) begin
			if (ctl.state == ST_CAPTURE_DR) begin
				bsr_shift_reg <= {bsr_update_reg[OUT_CTRL_CELL], ring_sync_reg};
			end else if (ctl.state == ST_SHIFT_DR) begin
				bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || ctl.state == ST_TEST_RESET) begin
			bsr_update_reg <= '0;
			bsr_update_reg[OUT_CTRL_CELL] <= 1'b1;
		end else if (tck_rise && sel_boundary && ctl.state == ST_UPDATE_DR) begin
			bsr_update_reg <= bsr_shift_reg;
		end
	end

	// serial output and pin controls move on the falling test clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo <= serial_lsb;
			tdo_oe <= (ctl.state == ST_SHIFT_IR) || (ctl.state == ST_SHIFT_DR);
		end
	end

	// port reset returns the instruction to identification, so memory pins are released
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_out_force_z <= 1'b0;
			mem_out_test_drive <= 1'b0;
			mem_out_test_data <= '0;
		end else if (tck_fall) begin
			mem_out_force_z <= (ir_reg == INSTR_SAMPLE_OUTPUTS_OFF);
			mem_out_test_drive <= (ir_reg == INSTR_EXTERNAL_TEST) && bsr_update_reg[OUT_CTRL_CELL];
			mem_out_test_data <= bsr_update_reg[OUT_WIDTH-1:0];
		end
	end

	// axi4-lite write side: address and data held independently, then applied
	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign aw_held_next = do_write ? 1'b0 : (aw_held_reg || (s_axi_awvalid && s_axi_awready));
	assign w_held_next = do_write ? 1'b0 : (w_held_reg || (s_axi_wvalid && s_axi_wready));
	assign bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			s_axi_awready <= !aw_held_next && !bvalid_next;
			s_axi_wready <= !w_held_next && !bvalid_next;
			s_axi_bvalid <= bvalid_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
		end
	end

	// control register: software can hold the test port in reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reset_reg <= CTRL_RESET_VALUE[CTRL_RESET_BIT];
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			if (aw_addr_reg[3:2] == ADDR_CTRL[3:2]) begin
				if (w_strb_reg[0]) begin
					ctrl_reset_reg <= w_data_reg[CTRL_RESET_BIT];
				end
				s_axi_bresp <= RESP_OKAY;
			end else if (aw_addr_reg[3:2] == ADDR_STATUS[3:2] || aw_addr_reg[3:2] == ADDR_ID[3:2]
				|| aw_addr_reg[3:2] == ADDR_BOUNDARY[3:2]) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_DECERR;
			end
		end
	end

	// axi4-lite read side, one cycle from address to data
	always_comb begin
		read_word = '0;
		read_hit = 1'b1;
		unique case (s_axi_araddr[3:2])
			ADDR_CTRL[3:2]: read_word[CTRL_RESET_BIT] = ctrl_reset_reg;
			ADDR_STATUS[3:2]: begin
				read_word[STATUS_STATE_LSB +: 4] = ctl.state;
				read_word[STATUS_INSTR_LSB +: IR_WIDTH] = ir_reg;
				read_word[STATUS_OE_BIT] = tdo_oe;
			end
			ADDR_ID[3:2]: read_word = ID_CODE_VALUE;
			ADDR_BOUNDARY[3:2]: read_word[BSR_LEN-1:0] = bsr_update_reg;
		endcase
		if (s_axi_araddr[1:0] != 2'h0) begin
			read_hit = 1'b0;
		end
	end

	assign rvalid_next = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !rvalid_next;
			s_axi_rvalid <= rvalid_next;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata <= read_hit ? read_word : 32'h0000_0000;
				s_axi_rresp <= read_hit ? RESP_OKAY : RESP_DECERR;
			end
		end
	end
endmodule : memory_boundary_scan_tap

//--- verif/tap_props.sv
// concurrent checks on the test port pins and the register read path
`timescale 1ns/10ps
module tap_props import tap_pkg::*; (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic tck, // test clock pin
	input wire logic tms, // mode select pin
	input wire logic tdo, // serial data out
	input wire logic tdo_oe, // serial data out enable
	input wire logic mem_out_force_z, // memory outputs off
	input wire logic mem_out_test_drive, // memory outputs from scan cells
	input wire logic [OUT_WIDTH-1:0] mem_out_test_data, // scan values for outputs
	input wire logic [3:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic s_axi_rvalid, // read data valid
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp // read response
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic tck_q;
	logic [2:0] high_cnt;
	logic rise;
	assign rise = tck && !tck_q;
	// raw pin view; the port resamples tck, so it lags these counts by a few cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tck_q <= 1'b0;
			high_cnt <= 3'h0;
		end else begin
			tck_q <= tck;
			if (rise) begin
				high_cnt <= !tms ? 3'h0 : (high_cnt == 3'h5 ? 3'h5 : high_cnt + 3'h1);
			end
		end
	end
	a_five_high_reset: assert property (rise && tms && high_cnt == 3'h4 |-> ##[1:20]
		(!tdo_oe && !mem_out_force_z && !mem_out_test_drive)) else $error("five high rises did not reset");
	a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 1)) else $error("tdo moved with tck high");
	a_oe_on_fall: assert property ($changed(tdo_oe) |-> !$past(tck, 1) && !$past(tck, 2)) else $error("oe moved with tck high");
	a_pins_on_fall: assert property ($changed({mem_out_force_z, mem_out_test_drive, mem_out_test_data}) |->
		!$past(tck, 2)) else $error("memory test pins moved with tck high");
	a_oe_after_reset: assert property ($rose(aresetn) |-> !tdo_oe [*8]) else $error("tdo driven after reset");
	a_drive_excl: assert property (mem_out_force_z |-> !mem_out_test_drive) else $error("outputs off and driven");
	// a high tms rise always leaves the shift states, so the driver must be off by the next fall
	a_oe_leaves_shift: assert property (rise && tms |-> ##14 !tdo_oe) else $error("tdo driven outside shift");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
	a_misalign_decerr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0 |=>
		s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0) else $error("misaligned read not refused");
	c_tap_reset: cover property (rise && tms && high_cnt == 3'h4);
	c_test_drive: cover property ($rose(mem_out_test_drive));
	c_force_z: cover property ($rose(mem_out_force_z));
	c_misaligned: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0);
endmodule : tap_props
bind memory_boundary_scan_tap tap_props tap_props_i (.*);

//--- verif/jtag_tester.sv
// behavioural boundary scan controller on the far side of the serial pins
`timescale 1ns/10ps
module jtag_tester (
	input wire logic aclk, // system clock, paces the link
	output logic tck, // test clock, 64 ns period
	output logic tms, // mode select
	output logic tdi, // serial data in
	input wire logic tdo, // serial data out of the port
	input wire logic tdo_oe // high while the port drives tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// one tck period of 16 aclk; tdo read just before the rise, undriven line reads inverted
	task automatic step(input logic m, input logic v, output logic q);
		@(posedge aclk);
		tck <= 1'b0;
		tms <= m;
		tdi <= v;
		repeat (8) @(posedge aclk);
		q = tdo_oe ? tdo : ~tdo;
		tck <= 1'b1;
		repeat (7) @(posedge aclk);
	endtask : step
	// park tck low, then wait out sync and fall detect so the pins have settled on return
	task automatic idle();
		@(posedge aclk);
		tck <= 1'b0;
		repeat (6) @(posedge aclk);
	endtask : idle
	task automatic tap_reset();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		idle();
	endtask : tap_reset
	// from idle: capture, shift n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		idle();
	endtask : scan
endmodule : jtag_tester

//--- verif/testbench.sv
// self-checking bench for the boundary scan port
`timescale 1ns/10ps
module testbench import tap_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
	logic [31:0] s_axi_wdata = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, r, d;
	logic tck, tms, tdi, tdo, tdo_oe, mem_out_force_z, mem_out_test_drive;
	logic [BSR_LEN-2:0] ring_in = '0;
	logic [OUT_WIDTH-1:0] mem_out_test_data;
	logic [2:0] byp [4] = '{INSTR_BYPASS, INSTR_RESERVED_A, INSTR_RESERVED_B, INSTR_RESERVED_C};
	int errors = 0;
	int n_checks = 0;
	always #2 aclk = ~aclk;
	memory_boundary_scan_tap memory_boundary_scan_tap_i (.*);
	jtag_tester jtag_tester_i (.aclk, .tck, .tms, .tdi, .tdo, .tdo_oe);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		r = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(r & m, e);
	endtask : rdchk
	task automatic ir(input logic [2:0] c);
		jtag_tester_i.scan(1'b1, IR_WIDTH, {29'h0, c}, d);
		chk(32'(d[1:0]), 32'h1);
	endtask : ir
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		chk(32'(tdo_oe), 32'h0);
		rdchk(ADDR_STATUS, 32'hff, 32'({1'b0, INSTR_IDENTIFICATION_READ, ST_TEST_RESET}));
		rdchk(4'h2, 32'hffff_ffff, 32'h0);
		chk(32'(rsp), 32'(RESP_DECERR));
		wr(ADDR_ID, 32'hffff_ffff);
		chk(32'(rsp), 32'(RESP_OKAY));
		rdchk(ADDR_ID, 32'hffff_ffff, ID_CODE_VALUE);
		$display("test registers done");
		jtag_tester_i.tap_reset();
		jtag_tester_i.scan(1'b0, ID_WIDTH, 32'h0, d);
		chk(d, ID_CODE_VALUE);
		$display("test identification done");
		foreach (byp[k]) begin
			ir(byp[k]);
			rdchk(ADDR_STATUS, 32'hff, 32'({1'b0, byp[k], ST_RUN_IDLE}));
			jtag_tester_i.scan(1'b0, 5, 32'h16, d);
			chk(32'(d[4:0]), 32'h0c);
		end
		$display("test bypass done");
		ring_in <= 15'h5a3c;
		ir(INSTR_SAMPLE_PRELOAD);
		jtag_tester_i.scan(1'b0, BSR_LEN, 32'h00a5, d);
		chk(32'(d[15:0]), 32'h0000_da3c);
		rdchk(ADDR_BOUNDARY, 32'hffff, 32'h00a5);
		ir(INSTR_EXTERNAL_TEST);
		chk(32'({mem_out_force_z, mem_out_test_drive, mem_out_test_data}), 32'h0a5);
		jtag_tester_i.scan(1'b0, BSR_LEN, 32'h80c3, d);
		chk(32'(d[15:0]), 32'h0000_5a3c);
		chk(32'({mem_out_force_z, mem_out_test_drive, mem_out_test_data}), 32'h1c3);
		ir(INSTR_SAMPLE_OUTPUTS_OFF);
		chk(32'({mem_out_force_z, mem_out_test_drive}), 32'h2);
		jtag_tester_i.scan(1'b0, BSR_LEN, 32'h80c3, d);
		chk(32'(d[15:0]), 32'h0000_da3c);
		jtag_tester_i.tap_reset();
		chk(32'({mem_out_force_z, mem_out_test_drive}), 32'h0);
		rdchk(ADDR_STATUS, 32'hff, 32'({1'b0, INSTR_IDENTIFICATION_READ, ST_RUN_IDLE}));
		ir(INSTR_EXTERNAL_TEST);
		chk(32'({mem_out_test_drive, mem_out_test_data}), 32'h100);
		$display("test boundary done");
		wr(ADDR_CTRL, 32'h1);
		rdchk(ADDR_STATUS, 32'h7f, 32'({INSTR_IDENTIFICATION_READ, ST_TEST_RESET}));
		wr(ADDR_CTRL, 32'h0);
		rdchk(ADDR_CTRL, 32'h1, 32'h0);
		$display("test control reset done");
		tally_and_finish();
	end
endmodule : testbench
